// ### pkg/hbp_pkg.sv
package hbp_pkg;

   // Bus widths
   localparam int HBP_LO_ADDR_W = 8;
   localparam int HBP_HI_ADDR_W = 24;
   localparam int HBP_DATA_W = 16;

   // Reset levels of the strobe and direction drivers
   localparam logic HBP_STROBE_IDLE = 1'b1;
   localparam logic HBP_RW_READ = 1'b1;

   // Cycles from a register read request to valid read data
   localparam int HBP_RD_LATENCY = 1;

   // Operand size codes on the size pins
   typedef enum logic [1:0] {
      HBP_SIZE_LONG = 2'h0,
      HBP_SIZE_BYTE = 2'h1,
      HBP_SIZE_WORD = 2'h2,
      HBP_SIZE_TRIPLE = 2'h3
   } hbp_size_t;

   // Slave-role sequencer
   typedef enum logic [1:0] {
      HBP_SL_IDLE = 2'h0,
      HBP_SL_WAIT = 2'h1,
      HBP_SL_ACK = 2'h3
   } hbp_sl_state_t;

   // Master-role sequencer, Gray coded along the transfer path
   typedef enum logic [2:0] {
      HBP_M_IDLE = 3'h0,
      HBP_M_REQ = 3'h1,
      HBP_M_GRANT = 3'h3,
      HBP_M_ADDR = 3'h2,
      HBP_M_DATA = 3'h6,
      HBP_M_END = 3'h7
   } hbp_m_state_t;

   // Request toward the register file behind the port
   typedef struct packed {
      logic wr;
      logic rd;
      hbp_size_t size;
      logic [HBP_LO_ADDR_W-1:0] addr;
      logic [HBP_DATA_W-1:0] wdata;
   } hbp_reg_req_t;

   // Memory cycle request from the DMA engine
   typedef struct packed {
      logic valid;
      logic rw_n;
      logic word;
      logic [HBP_HI_ADDR_W+HBP_LO_ADDR_W-1:0] addr;
      logic [HBP_DATA_W-1:0] wdata;
   } hbp_dma_req_t;

endpackage

// ### test/hbp_host_port_chk.sv
`timescale 1ns/1ps
module hbp_host_port_chk (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Watched pins
   input wire logic i_cs_n,
   input wire logic i_transfer_ack_n,
   input wire logic o_address_strobe_n,
   input wire logic o_data_strobe_n,
   input wire logic o_rw_n,
   input wire logic o_strobe_oe,
   input wire hbp_pkg::hbp_size_t o_operand_size,
   input wire logic o_data_oe,
   input wire logic o_transfer_ack_oe,
   input wire logic o_bus_request_n,
   input wire hbp_pkg::hbp_reg_req_t o_reg_req,
   input wire logic o_dma_done
);
   import hbp_pkg::*;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   a_reg_select: assert property ((o_reg_req.wr || o_reg_req.rd) |-> $past(!i_cs_n))
      else $error("access without select");
   a_write_ack: assert property (o_reg_req.wr |=> o_transfer_ack_oe)
      else $error("no write ack");
   a_read_drive: assert property (o_reg_req.rd |=> o_data_oe && o_transfer_ack_oe)
      else $error("read not driven");
   a_addr_owned: assert property (!o_address_strobe_n |-> o_strobe_oe && o_bus_request_n)
      else $error("strobe without bus");
   a_data_timed: assert property (!o_data_strobe_n |-> !o_address_strobe_n && $stable(o_rw_n))
      else $error("data strobe out of cycle");
   a_grant_input: assert property (!o_bus_request_n |-> !o_transfer_ack_oe)
      else $error("ack driven in request");
   a_cycle_end: assert property (o_dma_done |-> $past(!i_transfer_ack_n && !o_data_strobe_n))
      else $error("cycle ended early");
   a_size_out: assert property (o_strobe_oe |-> o_operand_size inside {HBP_SIZE_BYTE, HBP_SIZE_WORD})
      else $error("bad master size");
   a_bus_release: assert property (o_dma_done |=> !o_strobe_oe && !o_data_oe)
      else $error("bus not released");
endmodule // hbp_host_port_chk

bind hbp_host_port hbp_host_port_chk u_chk (.*);

// ### test/hbp_mem_model.sv
`timescale 1ns/1ps
// Arbiter and memory: grants a request, then ends each strobed cycle, i_wait+1 cycles after it starts
module hbp_mem_model (
   // Clock, reset and bus
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_bus_request_n,
   input wire logic i_strobe_oe,
   input wire logic i_data_strobe_n,
   input wire logic [3:0] i_wait,
   output logic o_ack_pull
);
   logic [3:0] cnt_ff;
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_ff <= 4'h0;
         o_ack_pull <= 1'b0;
      end else if (!i_bus_request_n || (i_strobe_oe && !i_data_strobe_n)) begin
         cnt_ff <= cnt_ff + 4'h1;
         o_ack_pull <= (cnt_ff >= i_wait);
      end else begin
         cnt_ff <= 4'h0;
         o_ack_pull <= 1'b0;
      end
   end
endmodule // hbp_mem_model

// ### test/test_host_bus_slave_master_port.sv
`timescale 1ns/1ps
module test_host_bus_slave_master_port;
   import hbp_pkg::*;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_cs_n = 1'b1;
   logic i_data_strobe_n = 1'b1;
   logic i_rw_n = 1'b1;
   logic [7:0] i_addr = 8'h00;
   hbp_size_t i_operand_size = HBP_SIZE_WORD;
   logic [15:0] i_data = 16'h0000;
   logic [15:0] i_reg_rdata = 16'h9c3e;
   hbp_dma_req_t i_dma_req = '0;
   logic [3:0] mem_wait = 4'h0;
   logic ack_pull, i_transfer_ack_n, o_address_strobe_n, o_data_strobe_n, o_rw_n, o_strobe_oe;
   logic o_data_oe, o_dma_ready, o_transfer_ack_n, o_transfer_ack_oe, o_bus_request_n, o_dma_done;
   logic [7:0] o_addr;
   logic [23:0] o_addr_hi;
   logic [15:0] o_data, o_dma_rdata;
   hbp_size_t o_operand_size;
   hbp_reg_req_t o_reg_req;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #12.5 i_mclk = ~i_mclk;
   // Open-drain acknowledge: either party pulls it low
   assign i_transfer_ack_n = ~(o_transfer_ack_oe | ack_pull);

   hbp_host_port u_dut (.*);
   hbp_mem_model u_mem (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus_request_n(o_bus_request_n),
      .i_strobe_oe(o_strobe_oe), .i_data_strobe_n(o_data_strobe_n), .i_wait(mem_wait),
      .o_ack_pull(ack_pull));

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic host_acc(input logic rd, input logic sel_n, input logic [7:0] a, input hbp_size_t sz);
      @(posedge i_mclk);
      i_cs_n <= sel_n;
      i_data_strobe_n <= 1'b0;
      i_rw_n <= rd;
      i_addr <= a;
      i_operand_size <= sz;
      i_data <= {a, ~a};
      @(posedge i_mclk);
      #1;
      chk({o_reg_req.rd, o_reg_req.wr}, sel_n ? 2'b00 : (rd ? 2'b10 : 2'b01));
      if (!sel_n) chk({o_reg_req.addr, o_reg_req.size}, {a, sz});
      if (!sel_n && !rd) chk(o_reg_req.wdata, {a, ~a});
      @(posedge i_mclk);
      #1;
      chk({o_transfer_ack_oe, o_transfer_ack_n}, {!sel_n, 1'b0});
      chk({o_reg_req.rd, o_reg_req.wr}, 2'b00);
      if (rd && !sel_n) chk({o_data_oe, o_data}, {1'b1, 16'h9c3e});
      @(posedge i_mclk);
      i_cs_n <= 1'b1;
      i_data_strobe_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      #1;
      chk({o_transfer_ack_oe, o_data_oe}, 0);
   endtask

   task automatic dma_cyc(input logic rd, input logic word, input logic [31:0] a, input logic [3:0] w);
      int n;
      n = 0;
      @(posedge i_mclk);
      mem_wait <= w;
      i_data <= 16'hc33c;
      i_dma_req <= '{1'b1, rd, word, a, 16'h5aa5};
      do begin
         @(posedge i_mclk);
         #1;
         n++;
         if (!o_data_strobe_n) begin
            chk({o_strobe_oe, o_rw_n, o_addr_hi, o_addr}, {1'b1, rd, a});
            chk(o_operand_size, word ? HBP_SIZE_WORD : HBP_SIZE_BYTE);
            chk(o_data_oe, !rd);
            chk({o_address_strobe_n, o_dma_ready}, 2'b00);
            if (!rd) chk(o_data, 16'h5aa5);
         end
      end while (o_dma_done !== 1'b1);
      chk(n, 8 + 2 * w);
      @(posedge i_mclk);
      i_dma_req.valid <= 1'b0;
      #1;
      chk({o_strobe_oe, o_data_oe}, 0);
      if (rd) chk(o_dma_rdata, 16'hc33c);
   endtask

   task automatic t_slave_sizes();
      for (int i = 0; i < 4; i++) begin
         host_acc(i[0], 1'b0, {6'h0f, i[1:0]}, hbp_size_t'(i));
      end
   endtask

   task automatic t_no_select();
      host_acc(1'b0, 1'b1, 8'h55, HBP_SIZE_BYTE);
      host_acc(1'b1, 1'b1, 8'haa, HBP_SIZE_WORD);
   endtask

   task automatic t_master();
      dma_cyc(1'b0, 1'b1, 32'h1234_5678, 4'h0);
      dma_cyc(1'b1, 1'b0, 32'h8765_4321, 4'h5);
   endtask

   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      repeat (3) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
      #1;
      chk({o_strobe_oe, o_data_oe, o_transfer_ack_oe, o_bus_request_n, o_dma_ready}, 5'h03);
      t_slave_sizes();
      t_no_select();
      t_master();
      test_done();
   end
endmodule // test_host_bus_slave_master_port

// ### verilog/hbp_host_port.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Register access only while chip select low
// - Master drives address strobe marking address valid
// - Slave data strobe captures writes, enables reads
// - Master drives data strobe timing memory transfers
// - Master drives read-not-write showing memory direction
// - Slave asserts acknowledge when register access completes
// - Acknowledge is bus-free input during bus request
// - Memory cycle ends only on memory acknowledge
// - Operand size in, byte/word out as master
module hbp_host_port (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Host pins, slave role
   input wire logic i_cs_n,
   input wire logic [hbp_pkg::HBP_LO_ADDR_W-1:0] i_addr,
   input wire hbp_pkg::hbp_size_t i_operand_size,
   // Shared strobe and direction pins
   input wire logic i_data_strobe_n,
   input wire logic i_rw_n,
   output logic o_address_strobe_n,
   output logic o_data_strobe_n,
   output logic o_rw_n,
   output logic o_strobe_oe,
   // Master address and size drivers
   output logic [hbp_pkg::HBP_LO_ADDR_W-1:0] o_addr,
   output logic [hbp_pkg::HBP_HI_ADDR_W-1:0] o_addr_hi,
   output hbp_pkg::hbp_size_t o_operand_size,
   // Data bus
   input wire logic [hbp_pkg::HBP_DATA_W-1:0] i_data,
   output logic [hbp_pkg::HBP_DATA_W-1:0] o_data,
   output logic o_data_oe,
   // Open-drain acknowledge and bus request
   input wire logic i_transfer_ack_n,
   output logic o_transfer_ack_n,
   output logic o_transfer_ack_oe,
   output logic o_bus_request_n,
   // Register file side
   output hbp_pkg::hbp_reg_req_t o_reg_req,
   input wire logic [hbp_pkg::HBP_DATA_W-1:0] i_reg_rdata,
   // DMA side
   input wire hbp_pkg::hbp_dma_req_t i_dma_req,
   output logic o_dma_ready,
   output logic o_dma_done,
   output logic [hbp_pkg::HBP_DATA_W-1:0] o_dma_rdata
);
   import hbp_pkg::*;

   hbp_sl_state_t sl_state_ff;
   hbp_sl_state_t nxt_sl_state;
   hbp_m_state_t m_state_ff;
   hbp_m_state_t nxt_m_state;
   hbp_dma_req_t dma_ff;
   logic sl_rd_ff;
   logic slave_sel;
   logic master_idle;

   assign master_idle = (m_state_ff == HBP_M_IDLE);
   // Slave access exists only outside master ownership
   assign slave_sel = !i_cs_n && !i_data_strobe_n && master_idle;

   // Slave sequencer
   always_comb begin
      nxt_sl_state = sl_state_ff;
      unique case (sl_state_ff)
         HBP_SL_IDLE: begin
            if (slave_sel) begin
               nxt_sl_state = HBP_SL_WAIT;
            end
         end
         HBP_SL_WAIT: begin
            nxt_sl_state = HBP_SL_ACK;
         end
         HBP_SL_ACK: begin
            // Hold acknowledge until the host drops its strobe or its chip select
            if (i_cs_n || i_data_strobe_n) begin
               nxt_sl_state = HBP_SL_IDLE;
            end
         end
         default: begin
            nxt_sl_state = HBP_SL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sl_state_ff <= HBP_SL_IDLE;
      end else begin
         sl_state_ff <= nxt_sl_state;
      end
   end

   // Register file request, one-cycle strobes
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_req <= '0;
         sl_rd_ff <= 1'b0;
      end else begin
         o_reg_req.wr <= 1'b0;
         o_reg_req.rd <= 1'b0;
         if (sl_state_ff == HBP_SL_IDLE && slave_sel) begin
            o_reg_req.wr <= !i_rw_n;
            o_reg_req.rd <= i_rw_n;
            o_reg_req.size <= i_operand_size;
            o_reg_req.addr <= i_addr;
            o_reg_req.wdata <= i_data;
            sl_rd_ff <= i_rw_n;
         end
      end
   end

   // Acknowledge driver: slave completion only, never during bus request
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_transfer_ack_oe <= 1'b0;
         o_transfer_ack_n <= 1'b0;
      end else begin
         o_transfer_ack_n <= 1'b0;
         o_transfer_ack_oe <= (nxt_sl_state == HBP_SL_ACK) && o_bus_request_n;
      end
   end

   // Master sequencer
   always_comb begin
      nxt_m_state = m_state_ff;
      unique case (m_state_ff)
         HBP_M_IDLE: begin
            if (i_dma_req.valid && sl_state_ff == HBP_SL_IDLE && !slave_sel) begin
               nxt_m_state = HBP_M_REQ;
            end
         end
         HBP_M_REQ: begin
            // Wait for the bus-free indication
            if (!i_transfer_ack_n) begin
               nxt_m_state = HBP_M_GRANT;
            end
         end
         HBP_M_GRANT: begin
            // Let the grant acknowledge drop before the cycle starts
            if (i_transfer_ack_n) begin
               nxt_m_state = HBP_M_ADDR;
            end
         end
         HBP_M_ADDR: begin
            nxt_m_state = HBP_M_DATA;
         end
         HBP_M_DATA: begin
            if (!i_transfer_ack_n) begin
               nxt_m_state = HBP_M_END;
            end
         end
         HBP_M_END: begin
            nxt_m_state = HBP_M_IDLE;
         end
         default: begin
            nxt_m_state = HBP_M_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         m_state_ff <= HBP_M_IDLE;
      end else begin
         m_state_ff <= nxt_m_state;
      end
   end

   // DMA request capture and handshake
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dma_ff <= '0;
         o_dma_ready <= 1'b0;
         o_dma_done <= 1'b0;
         o_dma_rdata <= '0;
      end else begin
         o_dma_ready <= (nxt_m_state == HBP_M_IDLE) && (sl_state_ff == HBP_SL_IDLE);
         o_dma_done <= (m_state_ff == HBP_M_DATA) && !i_transfer_ack_n;
         if (master_idle && nxt_m_state == HBP_M_REQ) begin
            dma_ff <= i_dma_req;
         end
         if (m_state_ff == HBP_M_DATA && !i_transfer_ack_n && dma_ff.rw_n) begin
            o_dma_rdata <= i_data;
         end
      end
   end

   // Bus request output
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_bus_request_n <= 1'b1;
      end else begin
         o_bus_request_n <= (nxt_m_state != HBP_M_REQ);
      end
   end

   // Master strobe, direction, address and size drivers
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_address_strobe_n <= HBP_STROBE_IDLE;
         o_data_strobe_n <= HBP_STROBE_IDLE;
         o_rw_n <= HBP_RW_READ;
         o_strobe_oe <= 1'b0;
         o_addr <= '0;
         o_addr_hi <= '0;
         o_operand_size <= HBP_SIZE_BYTE;
      end else begin
         // Drivers float outside ownership
         o_strobe_oe <= (nxt_m_state == HBP_M_ADDR) || (nxt_m_state == HBP_M_DATA)
            || (nxt_m_state == HBP_M_END);
         o_address_strobe_n <= !((nxt_m_state == HBP_M_ADDR)
            || (nxt_m_state == HBP_M_DATA));
         o_data_strobe_n <= !(nxt_m_state == HBP_M_DATA);
         if (m_state_ff == HBP_M_GRANT) begin
            o_rw_n <= dma_ff.rw_n;
            o_addr <= dma_ff.addr[HBP_LO_ADDR_W-1:0];
            o_addr_hi <= dma_ff.addr[HBP_HI_ADDR_W+HBP_LO_ADDR_W-1:HBP_LO_ADDR_W];
            o_operand_size <= dma_ff.word ? HBP_SIZE_WORD : HBP_SIZE_BYTE;
         end
      end
   end

   // Data bus: slave read data or master write data
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_data <= '0;
         o_data_oe <= 1'b0;
      end else begin
         if (sl_state_ff == HBP_SL_WAIT && sl_rd_ff) begin
            o_data <= i_reg_rdata;
         end else if (m_state_ff == HBP_M_GRANT) begin
            o_data <= dma_ff.wdata;
         end
         o_data_oe <= ((nxt_sl_state == HBP_SL_ACK) && sl_rd_ff)
            || (!dma_ff.rw_n && ((nxt_m_state == HBP_M_ADDR)
            || (nxt_m_state == HBP_M_DATA)));
      end
   end

endmodule // hbp_host_port
